// File: design/tdd_pkg.sv
/*
  package for the terminal delay and debounce block: register map, field
  layout, reset values and timing counts.
  assumes a 20 mhz clock and an axi4-lite master with 32-bit data.
*/
`default_nettype none
package tdd_pkg;
  // clock and time base
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned TICK_MS       = 1;      // base tick period, ms
  localparam int unsigned MS_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned FILT_TICK_MS  = 2;      // filter sample period
  // delays are held in tenths of a second
  localparam int unsigned DLY_STEP_MS   = 100;
  localparam int unsigned DLY_MAX       = 1000;   // 100.0 s
  localparam int unsigned DLY_W         = 10;
  localparam int unsigned RESP_MAX      = 200;
  localparam int unsigned RESP_W        = 8;
  // counts
  localparam int unsigned N_OUT         = 6;
  localparam int unsigned N_IN          = 9;
  // register map, byte addresses
  localparam logic [7:0] ADDR_DLY_BASE  = 8'h00; // out k: on at 8k, off 8k+4
  localparam logic [7:0] ADDR_RESP_BASE = 8'h40; // input k at 0x40 + 4k
  localparam logic [7:0] ADDR_STATUS    = 8'h80; // live levels
  // status fields
  localparam int unsigned ST_OUT_LSB    = 0;
  localparam int unsigned ST_IN_LSB     = 8;
  localparam int unsigned ST_RAW_LSB    = 20;
  // reset values and bus response codes
  localparam logic [DLY_W-1:0]  DLY_RST  = 10'h000;
  localparam logic [RESP_W-1:0] RESP_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY       = 2'b00;
  localparam logic [1:0] RESP_SLVERR     = 2'b10;
endpackage
`default_nettype wire

// File: design/tdd_top.sv
/*
  terminal delay and debounce: per-output on/off delays for six output
  terminals and a sampling filter for nine input terminals, with settings
  held in an axi4-lite register file.
  assumes one 20 mhz clock, synchronous active-high reset, raw pins async.
*/
`default_nettype none
module tdd_top #(
  parameter int unsigned MS_CYCLES = tdd_pkg::MS_CYCLES
) (
  input  wire logic                      ref_clk,
  input  wire logic                      srst,
  input  wire logic [tdd_pkg::N_OUT-1:0] out_cond,
  output logic      [tdd_pkg::N_OUT-1:0] out_level,
  input  wire logic [7:0]                in_pin,
  input  wire logic                      forward_run_input,
  output logic      [tdd_pkg::N_IN-1:0]  in_level,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);
  localparam int unsigned NO = tdd_pkg::N_OUT;
  localparam int unsigned NI = tdd_pkg::N_IN;
  localparam int unsigned DW = tdd_pkg::DLY_W;
  localparam int unsigned RW = tdd_pkg::RESP_W;
  localparam int unsigned MSW = $clog2(MS_CYCLES + 1);

  // elaboration check on the dividers: the filter phase bit only
  // serves a sample period of two millisecond ticks
  if (MS_CYCLES < 1 || tdd_pkg::FILT_TICK_MS != 2) begin : g_chk
    $error("divider settings not supported");
  end

  // whole state of the block
  typedef struct packed {
    logic [MSW-1:0]         ms_cnt;     // clock divider to 1 ms
    logic [6:0]             dms_cnt;    // ms within one 0.1 s step
    logic                   filt_ph;    // splits ms ticks into 2 ms ticks
    logic [NO-1:0][DW-1:0]  on_dly;     // on-delay settings, 0.1 s units
    logic [NO-1:0][DW-1:0]  off_dly;    // off-delay settings
    logic [NO-1:0][DW-1:0]  dly_cnt;    // running delay counters
    logic [NO-1:0]          out_q;      // delayed output levels
    logic [NI-1:0][RW-1:0]  resp;       // response time settings
    logic [NI-1:0][RW-1:0]  agree_cnt;  // consecutive equal samples
    logic [NI-1:0]          sync1;      // first synchroniser stage
    logic [NI-1:0]          sync2;      // second synchroniser stage
    logic [NI-1:0]          filt_q;     // filtered input levels
    logic                   aw_got;     // write address held
    logic                   w_got;      // write data held
    logic [7:0]             aw_addr;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
  } tdd_state_t;

  tdd_state_t st_ff;    // registered state
  tdd_state_t nxt_st;   // next state

  // decode of a delay register address: index, off flag, hit
  function automatic logic [4:0] tdd_dly_dec(input logic [7:0] a);
    logic [4:0] r;
    r = {1'b0, a[2], a[5:3]};
    if (a[7:6] == 2'b00 && a[1:0] == 2'b00 && a[5:3] < 3'(NO)) begin
      r[4] = 1'b1;
    end
    return r;
  endfunction

  // decode of a response register address: index and hit
  function automatic logic [4:0] tdd_resp_dec(input logic [7:0] a);
    logic [4:0] r;
    r = {1'b0, a[5:2]};
    if (a[7:6] == 2'b01 && a[1:0] == 2'b00 && a[5:2] < 4'(NI)) begin
      r[4] = 1'b1;
    end
    return r;
  endfunction

  logic        ms_tick;    // one-cycle 1 ms enable
  logic        step_tick;  // one-cycle 0.1 s enable
  logic        filt_tick;  // one-cycle 2 ms enable
  logic [NI-1:0] raw_in;   // pins gathered, forward run on top bit
  logic [4:0]  wdec;
  logic [4:0]  wrdec;
  logic [4:0]  rdec;
  logic [4:0]  rrdec;
  logic        do_wr;

  assign raw_in = {forward_run_input, in_pin};

  // next-state logic
  always_comb begin
    nxt_st = st_ff;
    // dividers
    ms_tick = (st_ff.ms_cnt == MSW'(MS_CYCLES - 1));
    step_tick = ms_tick
      && (st_ff.dms_cnt == 7'(tdd_pkg::DLY_STEP_MS - 1));
    filt_tick = ms_tick && st_ff.filt_ph;
    nxt_st.ms_cnt = ms_tick ? '0 : st_ff.ms_cnt + MSW'(1);
    if (ms_tick) begin
      nxt_st.filt_ph = ~st_ff.filt_ph;
      nxt_st.dms_cnt = step_tick ? '0 : st_ff.dms_cnt + 7'd1;
    end
    // output delay per terminal
    for (int i = 0; i < NO; i++) begin
      if (out_cond[i] == st_ff.out_q[i]) begin
        nxt_st.dly_cnt[i] = '0; // condition agrees, restart timer
      end else if (out_cond[i] && st_ff.on_dly[i] == '0) begin
        nxt_st.out_q[i] = 1'b1;
      end else if (!out_cond[i] && st_ff.off_dly[i] == '0) begin
        nxt_st.out_q[i] = 1'b0;
      end else if (step_tick) begin
        // own settings decide when the level follows
        if (st_ff.dly_cnt[i] + DW'(1) >=
            (out_cond[i] ? st_ff.on_dly[i] : st_ff.off_dly[i])) begin
          nxt_st.out_q[i] = out_cond[i];
          nxt_st.dly_cnt[i] = '0;
        end else begin
          nxt_st.dly_cnt[i] = st_ff.dly_cnt[i] + DW'(1);
        end
      end
    end
    // input filter per terminal
    nxt_st.sync1 = raw_in;
    nxt_st.sync2 = st_ff.sync1;
    for (int j = 0; j < NI; j++) begin
      if (filt_tick) begin
        if (st_ff.sync2[j] == st_ff.filt_q[j]) begin
          nxt_st.agree_cnt[j] = '0;
        end else if (st_ff.agree_cnt[j] >= st_ff.resp[j]) begin
          nxt_st.filt_q[j] = st_ff.sync2[j];
          nxt_st.agree_cnt[j] = '0;
        end else begin
          nxt_st.agree_cnt[j] = st_ff.agree_cnt[j] + RW'(1);
        end
      end
    end
    // write channel: address and data taken in either order
    if (s_axi_awvalid && !st_ff.aw_got) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_ff.w_got) begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    wdec = tdd_dly_dec(st_ff.aw_addr);
    wrdec = tdd_resp_dec(st_ff.aw_addr);
    do_wr = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
    if (do_wr) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = tdd_pkg::RESP_OKAY;
      if (wdec[4] && &st_ff.w_strb[1:0]
          && st_ff.w_data[15:0] <= 16'(tdd_pkg::DLY_MAX)) begin
        if (wdec[3]) begin
          nxt_st.off_dly[wdec[2:0]] = st_ff.w_data[DW-1:0];
        end else begin
          nxt_st.on_dly[wdec[2:0]] = st_ff.w_data[DW-1:0];
        end
      end else if (wrdec[4] && st_ff.w_strb[0]
                   && st_ff.w_data[15:0] <= 16'(tdd_pkg::RESP_MAX)) begin
        nxt_st.resp[wrdec[3:0]] = st_ff.w_data[RW-1:0];
      end else begin
        nxt_st.bresp = tdd_pkg::RESP_SLVERR; // unmapped, out of range or missing byte lanes
      end
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // read channel
    rdec = tdd_dly_dec(s_axi_araddr);
    rrdec = tdd_resp_dec(s_axi_araddr);
    if (s_axi_arvalid && !st_ff.rvalid) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = tdd_pkg::RESP_OKAY;
      nxt_st.rdata = '0;
      if (rdec[4]) begin
        nxt_st.rdata[DW-1:0] = rdec[3] ? st_ff.off_dly[rdec[2:0]]
                                       : st_ff.on_dly[rdec[2:0]];
      end else if (rrdec[4]) begin
        nxt_st.rdata[RW-1:0] = st_ff.resp[rrdec[3:0]];
      end else if (s_axi_araddr == tdd_pkg::ADDR_STATUS) begin
        nxt_st.rdata[tdd_pkg::ST_OUT_LSB +: NO] = st_ff.out_q;
        nxt_st.rdata[tdd_pkg::ST_IN_LSB +: NI] = st_ff.filt_q;
        nxt_st.rdata[tdd_pkg::ST_RAW_LSB +: NI] = st_ff.sync2;
      end else begin
        nxt_st.rresp = tdd_pkg::RESP_SLVERR;
      end
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    // synchronous reset
    if (srst) begin
      nxt_st = '0;
      for (int k = 0; k < NO; k++) begin
        nxt_st.on_dly[k] = tdd_pkg::DLY_RST;
        nxt_st.off_dly[k] = tdd_pkg::DLY_RST;
      end
      for (int k = 0; k < NI; k++) begin
        nxt_st.resp[k] = tdd_pkg::RESP_RST;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    st_ff <= nxt_st;
  end

  // outputs
  assign out_level     = st_ff.out_q;
  assign in_level      = st_ff.filt_q;
  assign s_axi_awready = !st_ff.aw_got;
  assign s_axi_wready  = !st_ff.w_got;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rresp   = st_ff.rresp;
  assign s_axi_rdata   = st_ff.rdata;
endmodule
`default_nettype wire

// File: tb/tdd_asserts.sv
/*
  checker for the tdd_top ports: bus handshakes, reset levels, terminals.
  assumes it is bound into every tdd_top instance.
*/
`default_nettype none
module tdd_asserts #(
  parameter int unsigned MS_CYCLES = tdd_pkg::MS_CYCLES
) (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic [5:0]  out_cond,
  input wire logic [5:0]  out_level,
  input wire logic [7:0]  in_pin,
  input wire logic        forward_run_input,
  input wire logic [8:0]  in_level,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  // one clock domain, reset quiets every check but the two reset checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_rst_levels: assert property (disable iff (1'b0)
    srst |=> out_level == 6'h00 && in_level == 9'h000)
    else $error("levels not cleared by reset");
  a_rst_ready: assert property (disable iff (1'b0) srst |=> s_axi_awready
    && s_axi_wready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
    else $error("bus not idle after reset");
  a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_wr_latency: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_r_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  // an output may only move to the condition seen at the edge
  a_out_path: assert property (
    ((out_level ^ $past(out_level)) & (out_level ^ $past(out_cond))) == 6'h00)
    else $error("output moved against its condition");
  // a filtered input may only move to the pin level seen three edges
  // earlier: two synchroniser stages, then the filter register
  a_in_path: assert property (
    ((in_level ^ $past(in_level)) &
     (in_level ^ $past({forward_run_input, in_pin}, 3))) == 9'h000)
    else $error("input moved against its pin");
  c_write: cover property (s_axi_awvalid && s_axi_awready);
  c_read: cover property (s_axi_arvalid && s_axi_arready);
  c_out: cover property ($rose(out_level[5]));
  c_in: cover property ($rose(in_level[8]));
endmodule
bind tdd_top tdd_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .ref_clk(ref_clk), .srst(srst), .out_cond(out_cond),
  .out_level(out_level), .in_pin(in_pin), .in_level(in_level),
  .forward_run_input(forward_run_input),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata));
`default_nettype wire

// File: tb/tdd_switch.sv
/*
  contact model for the raw input pins: a moved contact bounces briefly.
  assumes the shared bench clock.
*/
`default_nettype none
module tdd_switch (
  input  wire logic       ref_clk,
  input  wire logic [8:0] lvl,
  output logic      [8:0] pin
);
  logic [8:0] prev_ff = 9'h000;  // last commanded level
  logic [8:0] chg_ff  = 9'h000;  // contacts that moved
  logic [8:0] lfsr_ff = 9'h1a5;  // bounce pattern
  logic [3:0] cnt_ff  = 4'h0;    // bounce cycles left
  // only moved contacts bounce, then settle on the level
  always_ff @(posedge ref_clk) begin
    lfsr_ff <= {lfsr_ff[7:0], lfsr_ff[8] ^ lfsr_ff[4]};
    prev_ff <= lvl;
    if (lvl != prev_ff) begin
      cnt_ff <= 4'hf;
      chg_ff <= lvl ^ prev_ff;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
    pin <= (cnt_ff != 4'h0) ? lvl ^ (lfsr_ff & chg_ff) : lvl;
  end
endmodule
`default_nettype wire

// File: tb/tb_terminal_delay_and_debounce.sv
/*
  bench for tdd_top: settings over axi4-lite, output delays, input filter.
  assumes tdd_switch in front of the raw pins and a 50 ns clock.
*/
`default_nettype none
module tb_terminal_delay_and_debounce;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS = 10;        // shortened millisecond
  localparam int TK = 2 * MS;    // filter sample period
  localparam int ST = 100 * MS;  // delay step
  logic        ref_clk, srst, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready;
  logic [5:0]  out_cond, out_level;
  logic [8:0]  lvl, pin, in_level, acc;
  logic [3:0]  wstrb;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  integer      seed, bad_count, check_count;
  int          dl[12], rs[9], t[9];
  tdd_top #(.MS_CYCLES(MS)) u_dut (
    .ref_clk(ref_clk), .srst(srst), .out_cond(out_cond),
    .out_level(out_level), .in_pin(pin[7:0]), .forward_run_input(pin[8]),
    .in_level(in_level), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  tdd_switch u_sw (.ref_clk(ref_clk), .lvl(lvl), .pin(pin));
  // free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // expected window of a measured change, in cycles
  function automatic int lim(bit inp, int n, bit hi);
    if (inp) return hi ? TK * (n + 2) + 5 : TK * n + 4;
    if (n == 0) return 2;
    return hi ? n * ST + 2 : (n - 1) * ST + 1;
  endfunction
  task automatic report_and_stop;
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_t(input int got, input bit inp, input int n);
    check_count++;
    if (got < lim(inp, n, 0) || got > lim(inp, n, 1)) begin
      bad_count++;
      $display("[ERR] %0t change after %0d cycles", $time, got);
    end
  endtask
  // one write, checked response
  task automatic wrc(input logic [7:0] a, input int d, input logic [1:0] e);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= 32'(d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk_v(32'(bresp), 32'(e));
  endtask
  // one read, checked response, and data when the expected response is okay
  task automatic rdc(input logic [7:0] a, input int d, input logic [1:0] e);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    if (e == tdd_pkg::RESP_OKAY) chk_v(rdata, 32'(d));
    chk_v(32'(rresp), 32'(e));
  endtask
  // cycles until each terminal reaches its goal
  task automatic meas(input bit inp, input logic [8:0] goal);
    logic [8:0] done;
    int         n;
    done = inp ? 9'h000 : 9'h1c0;
    n = 0;
    // a terminal that never arrives keeps zero and fails its window
    for (int i = 0; i < 9; i++) t[i] = 0;
    while (done != 9'h1ff && n < 6000) begin
      @(posedge ref_clk);
      n++;
      for (int i = 0; i < 9; i++)
        if (!done[i] && (inp ? in_level[i] : out_level[i % 6]) === goal[i])
        begin
          t[i] = n;
          done[i] = 1'b1;
        end
    end
  endtask
  // watchdog
  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    seed = 32'hecba;
    bad_count = 0;
    check_count = 0;
    {srst, out_cond, lvl, awaddr, araddr, wdata} = {1'b1, 63'h0};
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    wstrb = 4'hf;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    rdc(tdd_pkg::ADDR_RESP_BASE + 8'h20, 0, tdd_pkg::RESP_OKAY);
    rdc(8'h84, 0, tdd_pkg::RESP_SLVERR);
    wrc(tdd_pkg::ADDR_RESP_BASE + 8'h20, 200, tdd_pkg::RESP_OKAY);
    wrc(tdd_pkg::ADDR_RESP_BASE + 8'h20, 201, tdd_pkg::RESP_SLVERR);
    rdc(tdd_pkg::ADDR_RESP_BASE + 8'h20, 200, tdd_pkg::RESP_OKAY);
    wrc(8'h04, 1000, tdd_pkg::RESP_OKAY);
    wrc(8'h04, 1001, tdd_pkg::RESP_SLVERR);
    rdc(8'h04, 1000, tdd_pkg::RESP_OKAY);
    // a delay write without both low byte lanes is refused, not stored
    wstrb <= 4'h1;
    wrc(8'h08, 5, tdd_pkg::RESP_SLVERR);
    wstrb <= 4'hf;
    rdc(8'h08, 0, tdd_pkg::RESP_OKAY);
    rs[8] = 200;
    for (int k = 0; k < 12; k++) begin
      dl[k] = (k < 2) ? 0 : 1 + $unsigned($random(seed)) % 3;
      wrc(8'(4 * k), dl[k], tdd_pkg::RESP_OKAY);
      rdc(8'(4 * k), dl[k], tdd_pkg::RESP_OKAY);
    end
    for (int k = 0; k < 8; k++) begin
      rs[k] = 1 + $unsigned($random(seed)) % 6;
      wrc(tdd_pkg::ADDR_RESP_BASE + 8'(4 * k), rs[k], 2'b00);
    end
    out_cond <= 6'h3f;
    meas(1'b0, 9'h03f);
    for (int k = 0; k < 6; k++) chk_t(t[k], 1'b0, dl[2 * k]);
    out_cond <= 6'h00;
    meas(1'b0, 9'h000);
    for (int k = 0; k < 6; k++) chk_t(t[k], 1'b0, dl[2*k+1]);
    lvl <= 9'h1ff;
    meas(1'b1, 9'h1ff);
    for (int k = 0; k < 9; k++) chk_t(t[k], 1'b1, rs[k]);
    lvl <= 9'h000;
    repeat (2) @(posedge ref_clk);
    lvl <= 9'h1ff;
    // a short dip must not reach any filtered level at any edge
    acc = 9'h1ff;
    repeat (8 * TK) begin
      @(posedge ref_clk);
      acc = acc & in_level;
    end
    chk_v(32'(acc), 32'h1ff);
    rdc(tdd_pkg::ADDR_STATUS, (32'h1ff << tdd_pkg::ST_IN_LSB)
        | (32'h1ff << tdd_pkg::ST_RAW_LSB), tdd_pkg::RESP_OKAY);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    chk_v(32'({out_level, in_level}), 32'h0);
    // settings return to zero after a reset in mid-run
    rdc(8'h08, 0, tdd_pkg::RESP_OKAY);
    rdc(tdd_pkg::ADDR_RESP_BASE + 8'h20, 0, tdd_pkg::RESP_OKAY);
    report_and_stop();
  end
endmodule
`default_nettype wire
